/* verilog/yrcfg_consts.svh */
// Register offsets, field positions, reset values and scaling constants
`ifndef YRCFG_CONSTS_SVH
`define YRCFG_CONSTS_SVH
// Register indices; byte address is four times the index
`define YRCFG_IDX_CTRL     16'h3000
`define YRCFG_IDX_ADDR_LO  16'h3002
`define YRCFG_IDX_ADDR_HI  16'h3004
`define YRCFG_IDX_STATUS   16'h3010
// Control register fields
`define YRCFG_CTRL_TYPE_BIT   4
`define YRCFG_CTRL_MODE_MSB   2
`define YRCFG_CTRL_MODE_LSB   0
`define YRCFG_CTRL_RESET      16'h0005
`define YRCFG_ADDR_RESET      16'h0000
`define YRCFG_ADDR_HI_MSB     9
// Status register fields
`define YRCFG_STAT_BUSY_BIT   0
`define YRCFG_STAT_RANGE_BIT  1
`define YRCFG_STAT_TYPE_BIT   4
`define YRCFG_STAT_MODE_LSB   8
// Studio-range rescale: offsets and Q15 gains for 255/219 and 255/224
`define YRCFG_LUMA_OFS    10'sh010
`define YRCFG_CHROMA_OFS  10'sh080
`define YRCFG_LUMA_GAIN   18'sh0_9513
`define YRCFG_CHROMA_GAIN 18'sh0_91B7
`define YRCFG_GAIN_SHIFT  15
// Accepted core ranges
`define YRCFG_Y_MAX       28'sh000_00FF
`define YRCFG_C_MIN       28'shFFF_FF80
`define YRCFG_C_MAX       28'sh000_007F
`define YRCFG_FORCED      8'hFF
`endif

/* verilog/yrcfg_pkg.sv */
// Types shared by the input configuration block
package yrcfg_pkg;
  // Transfer mode codes selecting the coefficient set
  typedef enum logic [2:0] {
    YRCFG_MODE_RSV0  = 3'b000,
    YRCFG_MODE_709   = 3'b001,
    YRCFG_MODE_RSV2  = 3'b010,
    YRCFG_MODE_RSV3  = 3'b011,
    YRCFG_MODE_470M  = 3'b100,
    YRCFG_MODE_470BG = 3'b101,
    YRCFG_MODE_170M  = 3'b110,
    YRCFG_MODE_240M  = 3'b111
  } yrcfg_mode_t;
  // Conversion sequencing
  typedef enum logic [0:0] {
    YRCFG_IDLE = 1'b0,
    YRCFG_BUSY = 1'b1
  } yrcfg_state_t;
endpackage : yrcfg_pkg

/* verilog/yrcfg_scl_if.sv */
// Carrier between the top block and the input scaler
`timescale 1ns/1ns
`default_nettype none
interface yrcfg_scl_if;
  logic       studio;
  logic [7:0] y_raw;
  logic [7:0] u_raw;
  logic [7:0] v_raw;
  logic [7:0] y_cond;
  logic [7:0] u_cond;
  logic [7:0] v_cond;
  logic       over;
  // Top drives raw data, scaler answers combinationally
  modport ctl (output studio, y_raw, u_raw, v_raw,
               input  y_cond, u_cond, v_cond, over);
  modport scl (input  studio, y_raw, u_raw, v_raw,
               output y_cond, u_cond, v_cond, over);
endinterface : yrcfg_scl_if
`default_nettype wire

/* verilog/yrcfg_scale.sv */
// Input conditioning: studio-range rescale and core range check
`timescale 1ns/1ns
`default_nettype none
`include "yrcfg_consts.svh"
module yrcfg_scale (
  // Raw pixel in, conditioned pixel out
  yrcfg_scl_if.scl s
);
  logic signed [27:0] y_wide;
  logic signed [27:0] c_wide [2];
  logic               c_bad [2];
  logic [7:0]         c_out [2];
  logic               y_bad;

  // Luma: (Y-16)*255/219 in studio mode, plain in full range
  always_comb begin
    logic signed [9:0] diff;
    diff = 10'($signed({2'b00, s.y_raw})) - `YRCFG_LUMA_OFS;
    if (s.studio) begin
      y_wide = 28'((28'(diff) * 28'(`YRCFG_LUMA_GAIN)) >>>
               `YRCFG_GAIN_SHIFT); // R2
    end else begin
      y_wide = 28'($signed({20'h0_0000, s.y_raw})); // R1
    end
    y_bad = (y_wide < 28'sh000_0000) || (y_wide > `YRCFG_Y_MAX); // R4
  end

  // Chroma: centre on 128, then scale by 255/224 in studio mode
  for (genvar i = 0; i < 2; i++) begin : g_chroma
    always_comb begin
      logic signed [9:0] diff;
      diff = 10'($signed({2'b00, (i == 0) ? s.u_raw : s.v_raw}))
             - `YRCFG_CHROMA_OFS;
      if (s.studio) begin
        c_wide[i] = 28'((28'(diff) * 28'(`YRCFG_CHROMA_GAIN)) >>>
                    `YRCFG_GAIN_SHIFT); // R3
      end else begin
        c_wide[i] = 28'(diff); // R1
      end
      c_bad[i] = (c_wide[i] < `YRCFG_C_MIN) ||
                 (c_wide[i] > `YRCFG_C_MAX); // R4
      c_out[i] = c_wide[i][7:0];
    end
  end

  // Any component off range forces all outputs to full scale
  assign s.over   = y_bad || c_bad[0] || c_bad[1];
  assign s.y_cond = s.over ? `YRCFG_FORCED : y_wide[7:0]; // R5
  assign s.u_cond = s.over ? `YRCFG_FORCED : c_out[0];    // R5
  assign s.v_cond = s.over ? `YRCFG_FORCED : c_out[1];    // R5
endmodule : yrcfg_scale
`default_nettype wire

/* verilog/yrcfg_top.sv */
// Input configuration and conditioning for the colour space converter
//
// Operation
// [R1] Type bit 0 means full-range YUV 0..255, 1 means studio YCbCr.
// [R2] Studio luma becomes (Y-16)/(235-16)*255 before conversion.
// [R3] Studio chroma becomes (C-128)/(240-16)*255 before conversion.
// [R4] The core takes luma 0..255 and signed chroma -128..127.
// [R5] Conditioned data outside those ranges forces all outputs to 255.
// [R6] The coefficient set comes from control register bits 2..0.
// [R7] Codes 001,100,101(default),110,111 pick standards; others reserved.
// [R8] Low address register holds start address bits 15..0.
// [R9] High address register bits 9..0 hold address bits 25..16.
// [R10] Both address registers are read/write and reset to zero.
// [R11] Software keeps the two lowest start address bits at zero.
// [R12] Type and mode are caught at conversion start and held to its end.
`timescale 1ns/1ns
`default_nettype none
`include "yrcfg_consts.svh"
module yrcfg_top (
  // Clock and reset
  input  wire logic                   CLK_IN,
  input  wire logic                   SYS_RST_IN,
  // Wishbone slave
  input  wire logic                   WB_CYC_IN,
  input  wire logic                   WB_STB_IN,
  input  wire logic                   WB_WE_IN,
  input  wire logic [15:0]            WB_ADR_IN,
  input  wire logic [3:0]             WB_SEL_IN,
  input  wire logic [31:0]            WB_DAT_IN,
  output logic      [31:0]            WB_DAT_OUT,
  output logic                        WB_ACK_OUT,
  // Conversion framing
  input  wire logic                   FRAME_START_IN,
  input  wire logic                   WRITE_DONE_IN,
  // Raw pixel stream in
  input  wire logic                   PIX_VALID_IN,
  output logic                        PIX_READY_OUT,
  input  wire logic [7:0]             PIX_Y_IN,
  input  wire logic [7:0]             PIX_U_IN,
  input  wire logic [7:0]             PIX_V_IN,
  // Conditioned pixel stream out
  output logic                        PIX_VALID_OUT,
  input  wire logic                   PIX_READY_IN,
  output logic      [7:0]             PIX_Y_OUT,
  output logic      [7:0]             PIX_U_OUT,
  output logic      [7:0]             PIX_V_OUT,
  output logic                        PIX_FORCED_OUT,
  // Settings held for the running conversion, and its busy flag
  output yrcfg_pkg::yrcfg_mode_t      MODE_OUT,
  output logic                        STUDIO_OUT,
  output logic      [25:0]            START_ADDR_OUT,
  output logic                        BUSY_OUT
);
  import yrcfg_pkg::*;

  // Indices held as named words, since a literal cannot be part-selected
  localparam logic [15:0] IX_CTRL  = `YRCFG_IDX_CTRL;
  localparam logic [15:0] IX_LO    = `YRCFG_IDX_ADDR_LO;
  localparam logic [15:0] IX_HI    = `YRCFG_IDX_ADDR_HI;
  localparam logic [15:0] IX_STAT  = `YRCFG_IDX_STATUS;
  localparam logic [15:0] ADDR_RST = `YRCFG_ADDR_RESET;
  // Byte addresses are the register index shifted up by two
  localparam logic [15:0] BA_CTRL = {IX_CTRL[13:0], 2'b00};
  localparam logic [15:0] BA_LO   = {IX_LO[13:0], 2'b00};
  localparam logic [15:0] BA_HI   = {IX_HI[13:0], 2'b00};
  localparam logic [15:0] BA_STAT = {IX_STAT[13:0], 2'b00};

  logic [15:0]  ctrl_q;
  logic [15:0]  addr_lo_q;
  logic [9:0]   addr_hi_q;
  logic         range_err_q;
  logic         ack_q;
  logic [31:0]  rdat_q;
  yrcfg_state_t state_q;
  yrcfg_mode_t  mode_q;
  logic         studio_q;
  logic [25:0]  start_q;
  logic         in_rdy_q;
  logic         out_vld_q;
  logic [7:0]   y_q;
  logic [7:0]   u_q;
  logic [7:0]   v_q;
  logic         forced_q;
  logic         bus_req;
  logic         wr_en;
  logic         take;
  logic         drain;
  logic         hit_ctrl;
  logic         hit_lo;
  logic         hit_hi;
  logic         hit_stat;
  logic [15:0]  stat_word;
  logic [15:0]  rd_word;

  yrcfg_scl_if scl ();

  // Conditioning datapath, fed from the pixel inputs
  yrcfg_scale u_scale (
    .s (scl.scl)
  );
  assign scl.studio = studio_q;
  assign scl.y_raw  = PIX_Y_IN;
  assign scl.u_raw  = PIX_U_IN;
  assign scl.v_raw  = PIX_V_IN;

  // Bus decode; a request is served once, in the cycle before ack
  assign bus_req  = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wr_en    = bus_req && WB_WE_IN;
  assign hit_ctrl = (WB_ADR_IN == BA_CTRL);
  assign hit_lo   = (WB_ADR_IN == BA_LO);
  assign hit_hi   = (WB_ADR_IN == BA_HI);
  assign hit_stat = (WB_ADR_IN == BA_STAT);

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Control register: only type and mode bits are stored
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl_q <= `YRCFG_CTRL_RESET; // R7
    end else if (wr_en && hit_ctrl) begin
      if (WB_SEL_IN[0]) begin
        ctrl_q[`YRCFG_CTRL_TYPE_BIT] <=
          WB_DAT_IN[`YRCFG_CTRL_TYPE_BIT]; // R1
        ctrl_q[`YRCFG_CTRL_MODE_MSB:`YRCFG_CTRL_MODE_LSB] <=
          WB_DAT_IN[`YRCFG_CTRL_MODE_MSB:`YRCFG_CTRL_MODE_LSB]; // R6
      end
    end
  end

  // Start address, low half: each byte lane writes its own byte
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      addr_lo_q <= `YRCFG_ADDR_RESET; // R10
    end else if (wr_en && hit_lo) begin
      if (WB_SEL_IN[0]) begin
        addr_lo_q[7:0] <= WB_DAT_IN[7:0]; // R8
      end
      if (WB_SEL_IN[1]) begin
        addr_lo_q[15:8] <= WB_DAT_IN[15:8]; // R8
      end
    end
  end

  // Start address, high half: bits 15..10 are unused and read zero
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      addr_hi_q <= ADDR_RST[9:0]; // R10
    end else if (wr_en && hit_hi) begin
      if (WB_SEL_IN[0]) begin
        addr_hi_q[7:0] <= WB_DAT_IN[7:0]; // R9
      end
      if (WB_SEL_IN[1]) begin
        addr_hi_q[9:8] <= WB_DAT_IN[`YRCFG_ADDR_HI_MSB:8]; // R9
      end
    end
  end

  // Sticky range error; a new error in the clearing cycle survives
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      range_err_q <= 1'b0;
    end else if (take && scl.over) begin
      range_err_q <= 1'b1; // R5
    end else if (wr_en && hit_stat && WB_SEL_IN[0] &&
                 WB_DAT_IN[`YRCFG_STAT_RANGE_BIT]) begin
      range_err_q <= 1'b0;
    end
  end

  // Status word shows the settings in force, not the programmed ones
  always_comb begin
    stat_word = 16'h0000;
    stat_word[`YRCFG_STAT_BUSY_BIT]  = (state_q == YRCFG_BUSY);
    stat_word[`YRCFG_STAT_RANGE_BIT] = range_err_q;
    stat_word[`YRCFG_STAT_TYPE_BIT]  = studio_q;
    stat_word[`YRCFG_STAT_MODE_LSB +: 3] = mode_q;
  end

  // Read mux; unmapped addresses read zero but still ack
  always_comb begin
    rd_word = 16'h0000;
    if (hit_ctrl) begin
      rd_word = ctrl_q;
    end else if (hit_lo) begin
      rd_word = addr_lo_q; // R10
    end else if (hit_hi) begin
      rd_word = {6'h00, addr_hi_q}; // R10
    end else if (hit_stat) begin
      rd_word = stat_word;
    end
  end

  // Read data registered with the ack
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req) begin
      rdat_q <= {16'h0000, rd_word};
    end
  end

  // Conversion sequence: start latches settings, write done releases
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q <= YRCFG_IDLE;
    end else begin
      unique case (state_q)
        YRCFG_IDLE: begin
          if (FRAME_START_IN) begin
            state_q <= YRCFG_BUSY;
          end
        end
        YRCFG_BUSY: begin
          if (WRITE_DONE_IN && !out_vld_q) begin
            state_q <= YRCFG_IDLE; // R12
          end
        end
      endcase
    end
  end

  // Settings snapshot; a write during a conversion waits for the next
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      mode_q   <= YRCFG_MODE_470BG;
      studio_q <= 1'b0;
      start_q  <= 26'h000_0000;
    end else if (state_q == YRCFG_IDLE && FRAME_START_IN) begin
      mode_q   <= yrcfg_mode_t'(ctrl_q[`YRCFG_CTRL_MODE_MSB:
                                       `YRCFG_CTRL_MODE_LSB]); // R12
      studio_q <= ctrl_q[`YRCFG_CTRL_TYPE_BIT]; // R12
      start_q  <= {addr_hi_q, addr_lo_q}; // R11
    end
  end

  // Single-entry stage; ready is registered, so at most one pixel
  // every three cycles, traded for a short input timing path
  assign take  = in_rdy_q && PIX_VALID_IN;
  assign drain = out_vld_q && PIX_READY_IN;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      in_rdy_q  <= 1'b0;
      out_vld_q <= 1'b0;
    end else if (take) begin
      in_rdy_q  <= 1'b0;
      out_vld_q <= 1'b1;
    end else if (drain) begin
      in_rdy_q  <= 1'b0;
      out_vld_q <= 1'b0;
    end else begin
      in_rdy_q  <= (state_q == YRCFG_BUSY) && !out_vld_q &&
                   !WRITE_DONE_IN;
    end
  end

  // Output pixel register holds until drained
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      y_q      <= 8'h00;
      u_q      <= 8'h00;
      v_q      <= 8'h00;
      forced_q <= 1'b0;
    end else if (take) begin
      y_q      <= scl.y_cond; // R4
      u_q      <= scl.u_cond; // R4
      v_q      <= scl.v_cond; // R4
      forced_q <= scl.over;   // R5
    end
  end

  // Ports straight from flip-flops
  assign WB_ACK_OUT     = ack_q;
  assign WB_DAT_OUT     = rdat_q;
  assign PIX_READY_OUT  = in_rdy_q;
  assign PIX_VALID_OUT  = out_vld_q;
  assign PIX_Y_OUT      = y_q;
  assign PIX_U_OUT      = u_q;
  assign PIX_V_OUT      = v_q;
  assign PIX_FORCED_OUT = forced_q;
  assign MODE_OUT       = mode_q;   // R6
  assign STUDIO_OUT     = studio_q;
  assign START_ADDR_OUT = start_q;
  assign BUSY_OUT       = (state_q == YRCFG_BUSY);
endmodule : yrcfg_top
`default_nettype wire

/* tb/yrcfg_top_sva.sv */
// Port assertions for the input configuration block, with their bind
`timescale 1ns/1ns
`default_nettype none
module yrcfg_chk (
  // Clock and reset
  input wire logic                   CLK_IN,
  input wire logic                   SYS_RST_IN,
  // Register bus
  input wire logic                   WB_CYC_IN,
  input wire logic                   WB_STB_IN,
  input wire logic                   WB_ACK_OUT,
  // Conversion control and held settings
  input wire logic                   FRAME_START_IN,
  input wire logic                   BUSY_OUT,
  input wire yrcfg_pkg::yrcfg_mode_t MODE_OUT,
  input wire logic                   STUDIO_OUT,
  input wire logic [25:0]            START_ADDR_OUT,
  // Pixel streams
  input wire logic                   PIX_VALID_IN,
  input wire logic                   PIX_READY_OUT,
  input wire logic [7:0]             PIX_Y_IN,
  input wire logic [7:0]             PIX_U_IN,
  input wire logic                   PIX_VALID_OUT,
  input wire logic                   PIX_READY_IN,
  input wire logic [7:0]             PIX_Y_OUT,
  input wire logic [7:0]             PIX_U_OUT,
  input wire logic [7:0]             PIX_V_OUT,
  input wire logic                   PIX_FORCED_OUT
);
  import yrcfg_pkg::*;
  // Single clock domain, so one default clock and disable
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_take;
    PIX_READY_OUT && PIX_VALID_IN;
  endsequence
  // Bus answer is a single registered pulse
  chk_ack_after_req: assert property (s_req |=> WB_ACK_OUT)
    else $error("ack missing after request");
  chk_ack_one_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  // Conditioning results
  chk_forced_all_max: assert property (PIX_VALID_OUT && PIX_FORCED_OUT
    |-> {PIX_Y_OUT, PIX_U_OUT, PIX_V_OUT} == 24'hFF_FFFF)
    else $error("forced pixel not all ones");
  chk_full_range_pass: assert property (s_take ##0 !STUDIO_OUT
    |=> PIX_Y_OUT == $past(PIX_Y_IN) && !PIX_FORCED_OUT
        && PIX_U_OUT == ($past(PIX_U_IN) ^ 8'h80))
    else $error("full range pixel altered");
  chk_low_luma_forced: assert property (s_take ##0
    (STUDIO_OUT && PIX_Y_IN < 8'h10) |=> PIX_VALID_OUT && PIX_FORCED_OUT)
    else $error("studio luma below range not forced");
  // Output holds while the memory side stalls
  chk_out_hold: assert property (PIX_VALID_OUT && !PIX_READY_IN
    |=> PIX_VALID_OUT && $stable({PIX_Y_OUT, PIX_U_OUT, PIX_V_OUT}))
    else $error("output pixel changed while stalled");
  // Settings caught at start and held while busy
  chk_start_busy: assert property (FRAME_START_IN && !BUSY_OUT |=> BUSY_OUT)
    else $error("start did not raise busy");
  chk_held_settings: assert property (BUSY_OUT && $past(BUSY_OUT)
    |-> $stable({MODE_OUT, STUDIO_OUT, START_ADDR_OUT}))
    else $error("settings changed during conversion");
endmodule // yrcfg_chk
bind yrcfg_top yrcfg_chk u_chk (.CLK_IN, .SYS_RST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_ACK_OUT, .FRAME_START_IN, .BUSY_OUT, .MODE_OUT, .STUDIO_OUT,
  .START_ADDR_OUT, .PIX_VALID_IN, .PIX_READY_OUT, .PIX_Y_IN, .PIX_U_IN,
  .PIX_VALID_OUT, .PIX_READY_IN, .PIX_Y_OUT, .PIX_U_OUT, .PIX_V_OUT,
  .PIX_FORCED_OUT);
`default_nettype wire

/* tb/yrcfg_sink.sv */
// Memory-side sink model taking conditioned pixels
`timescale 1ns/1ns
`default_nettype none
module yrcfg_sink (
  // Clock, reset and stall select
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  // Conditioned pixel stream
  input  wire logic       valid_in,
  input  wire logic [7:0] y_in,
  input  wire logic [7:0] u_in,
  input  wire logic [7:0] v_in,
  input  wire logic       forced_in,
  output logic            ready_out
);
  logic [24:0] got_q [$];
  logic [1:0]  cnt_q;
  // Slow mode takes one cycle in four, so the block must hold its data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  assign ready_out = !slow_in || (cnt_q == 2'h3);
  // Record each pixel as memory would store it
  always @(posedge clk_in) begin
    if (valid_in && ready_out) begin
      got_q.push_back({forced_in, y_in, u_in, v_in});
    end
  end
endmodule // yrcfg_sink
`default_nettype wire

/* tb/yuv_rgb_input_config_tb.sv */
// Self-checking bench for the input configuration block
`timescale 1ns/1ns
`default_nettype none
module yuv_rgb_input_config_tb;
  import yrcfg_pkg::*;
  // One case: type, mode, raw pixel, expected pixel and forced flag
  typedef struct packed {
    logic       s;
    logic [2:0] m;
    logic [7:0] y, u, v, ey, eu, ev;
    logic       f;
  } yrcfg_row_t;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        fs = 1'b0, wd = 1'b0, pvld = 1'b0, slow = 1'b0;
  logic        ack, prdy, ovld, irdy, forced, busy, studio;
  logic [3:0]  sel = 4'h0;
  logic [15:0] adr = 16'h0000, rd;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic [7:0]  py = 8'h00, pu = 8'h00, pv = 8'h00, oy, ou, ov;
  logic [25:0] sa;
  yrcfg_mode_t mode;
  int          error_cnt = 0, check_count = 0;
  yrcfg_row_t  rows [9] = '{
    '{1'b1, 3'h0, 8'h10, 8'h10, 8'hF0, 8'h00, 8'h80, 8'h7F, 1'b0},
    '{1'b1, 3'h1, 8'hEB, 8'h80, 8'h80, 8'hFF, 8'h00, 8'h00, 1'b0},
    '{1'b1, 3'h2, 8'h0F, 8'h80, 8'h80, 8'hFF, 8'hFF, 8'hFF, 1'b1},
    '{1'b1, 3'h3, 8'h7E, 8'h80, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 1'b1},
    '{1'b0, 3'h4, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h80, 8'h7F, 1'b0},
    '{1'b0, 3'h5, 8'h80, 8'h80, 8'h7F, 8'h80, 8'h00, 8'hFF, 1'b0},
    '{1'b1, 3'h6, 8'hEC, 8'h80, 8'h80, 8'hFF, 8'hFF, 8'hFF, 1'b1},
    '{1'b1, 3'h7, 8'h7E, 8'h0F, 8'h80, 8'hFF, 8'hFF, 8'hFF, 1'b1},
    '{1'b1, 3'h5, 8'h7E, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 1'b0}
  };
  always #5 clk = ~clk;
  yrcfg_top u_dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .FRAME_START_IN(fs),
    .WRITE_DONE_IN(wd), .PIX_VALID_IN(pvld), .PIX_READY_OUT(prdy),
    .PIX_Y_IN(py), .PIX_U_IN(pu), .PIX_V_IN(pv), .PIX_VALID_OUT(ovld),
    .PIX_READY_IN(irdy), .PIX_Y_OUT(oy), .PIX_U_OUT(ou), .PIX_V_OUT(ov),
    .PIX_FORCED_OUT(forced), .MODE_OUT(mode), .STUDIO_OUT(studio),
    .START_ADDR_OUT(sa), .BUSY_OUT(busy));
  yrcfg_sink u_sink (.clk_in(clk), .rst_in(rst), .slow_in(slow),
    .valid_in(ovld), .y_in(oy), .u_in(ou), .v_in(ov),
    .forced_in(forced), .ready_out(irdy));
  task automatic check(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then idle a cycle
  task automatic wb(input logic w, input logic [3:0] s,
                    input logic [15:0] a, d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= s;
    adr  <= a;
    wdat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string n, input logic [15:0] a, exp);
    wb(1'b0, 4'h3, a, 16'h0000);
    check(n, rd, exp);
  endtask
  task automatic start_frame();
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
  endtask
  task automatic end_frame();
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    do @(posedge clk); while (busy !== 1'b0);
  endtask
  task automatic run_row(input yrcfg_row_t t);
    logic [24:0] got;
    wb(1'b1, 4'h1, 16'hC000, {11'h000, t.s, 1'b0, t.m});
    start_frame();
    py   <= t.y;
    pu   <= t.u;
    pv   <= t.v;
    pvld <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    pvld <= 1'b0;
    check("mode", mode, t.m);
    check("type", studio, t.s);
    check("start_addr", sa, 26'h3FF_AB34);
    while (u_sink.got_q.size() == 0) @(posedge clk);
    got = u_sink.got_q.pop_front();
    check("pixel", got, {t.f, t.ey, t.eu, t.ev});
    end_frame();
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence: registers, conditioning rows, then held settings
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset_mode", mode, YRCFG_MODE_470BG);
    rchk("ctrl_reset", 16'hC000, 16'h0005);
    rchk("lo_reset", 16'hC008, 16'h0000);
    rchk("hi_reset", 16'hC010, 16'h0000);
    wb(1'b1, 4'h3, 16'hC008, 16'hABCC);
    wb(1'b1, 4'h3, 16'hC010, 16'hFFFF);
    rchk("lo_rw", 16'hC008, 16'hABCC);
    rchk("hi_rw", 16'hC010, 16'h03FF);
    wb(1'b1, 4'h3, 16'hC020, 16'hFFFF);
    rchk("unmapped", 16'hC020, 16'h0000);
    // Mid-run reset must clear the high address register again
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("hi_reset2", 16'hC010, 16'h0000);
    wb(1'b1, 4'h3, 16'hC010, 16'h03FF);
    wb(1'b1, 4'h3, 16'hC008, 16'hABCC);
    wb(1'b1, 4'h1, 16'hC008, 16'h1234);
    rchk("lo_byte", 16'hC008, 16'hAB34);
    foreach (rows[i]) begin
      slow <= i[0];
      run_row(rows[i]);
    end
    // Sticky range flag, latched studio type and mode, then write-1 clear
    rchk("status", 16'hC040, 16'h0512);
    wb(1'b1, 4'h1, 16'hC040, 16'h0002);
    rchk("status_clr", 16'hC040, 16'h0510);
    // Writes and a second start during a conversion must not disturb it
    wb(1'b1, 4'h1, 16'hC000, 16'h0005);
    start_frame();
    do @(posedge clk); while (busy !== 1'b1);
    wb(1'b1, 4'h1, 16'hC000, 16'h0011);
    start_frame();
    @(posedge clk);
    check("held_mode", mode, 3'h5);
    check("held_type", studio, 1'b0);
    rchk("ctrl_new", 16'hC000, 16'h0011);
    end_frame();
    start_frame();
    do @(posedge clk); while (busy !== 1'b1);
    check("new_mode", mode, 3'h1);
    end_frame();
    complete_run();
  end
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule // yuv_rgb_input_config_tb
`default_nettype wire
